// ---- rtl/arith_pkg.sv ----
/*
 * Shared constants, flag layout and instruction carrier for the
 * binary accumulator arithmetic unit.
 * Assumes one clock and a sequencer that keeps each request stable.
 */
// Function
// - double add: acc plus 32-bit operand
// - double operand from memory is two consecutive memory words
// - single subtract: 16-bit acc minus 16-bit operand
// - double subtract: acc minus 32-bit operand
// - multiply 16-bit operand by 16-bit acc
// - divide: quotient to acc, remainder pushed
// - unusable divisor raises operand range error
// - zero flag follows accumulator result
// - negative flag follows accumulator sign
// - carry16 and carry32 flags on addition
// - borrow16 flag on both subtracts, borrow32 flag on double subtract only
// - sign error on bad signed double add
// - flags hold until an instruction rewrites them
// - pointer mode reads operand address from memory
package arith_pkg;

    // ----------------------------------------------------------------
    // widths, positions, reset values
    // ----------------------------------------------------------------
    localparam int WORD_W     = 16;
    localparam int ACC_W      = 32;
    localparam int ADDR_W     = 16;
    localparam int SIGN_BIT   = 31;
    localparam int HALF_MSB   = 15;
    localparam int DIV_STEPS  = 32;
    localparam logic [ACC_W-1:0]  ACC_RESET   = 32'h0000_0000;
    localparam logic [WORD_W-1:0] WORD_ZERO   = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_STEP   = 16'h0001;
    localparam logic [7:0]        FLAGS_RESET = 8'h00;

    // ----------------------------------------------------------------
    // instruction encodings
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        add_binary_double_op,
        sub_binary_op,
        sub_binary_double_op,
        mul_binary_op,
        div_binary_op
    } opcode_t;

    typedef enum logic [1:0] {
        src_direct,
        src_pointer,
        src_constant
    } src_mode_t;

    typedef struct packed {
        opcode_t           opcode;
        src_mode_t         src;
        logic [ADDR_W-1:0] addr;
        logic [ACC_W-1:0]  const_value;
    } instr_t;

    typedef struct packed {
        logic operand_range_error_flag;
        logic zero_result_flag;
        logic borrow16_flag;
        logic borrow32_flag;
        logic carry16_flag;
        logic carry32_flag;
        logic negative_result_flag;
        logic sign_error_flag;
    } status_flags_t;

endpackage : arith_pkg

// ---- rtl/operand_fetch.sv ----
/*
 * Operand fetch: constant, direct word(s) or pointer then word(s).
 * Assumes memory answers a held request with a one-cycle valid.
 */
`timescale 1ns/10ps
`default_nettype none
module operand_fetch
    import arith_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              start,
    input  wire src_mode_t         src,
    input  wire logic              double_word,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [ACC_W-1:0]  const_value,
    output logic                   mem_rd_req,
    output logic [ADDR_W-1:0]      mem_addr,
    input  wire logic              mem_rd_valid,
    input  wire logic [WORD_W-1:0] mem_rd_data,
    output logic                   operand_valid,
    output logic [ACC_W-1:0]       operand
);

    typedef enum logic [1:0] {f_idle, f_ptr, f_lo, f_hi} fetch_state_t;

    fetch_state_t      state_reg;
    logic              double_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [WORD_W-1:0] lo_reg;

    assign mem_rd_req = (state_reg != f_idle);
    assign mem_addr   = addr_reg;

    always_ff @(posedge clk) begin
        operand_valid <= 1'b0;
        if (!rst_n) begin
            state_reg  <= f_idle;
            double_reg <= 1'b0;
            addr_reg   <= '0;
            lo_reg     <= WORD_ZERO;
            operand    <= ACC_RESET;
        end else begin
            case (state_reg)
                f_idle: if (start) begin
                    double_reg <= double_word;
                    addr_reg   <= addr;
                    if (src == src_constant) begin
                        operand_valid <= 1'b1;
                        operand <= double_word ? const_value
                                 : {WORD_ZERO, const_value[WORD_W-1:0]};
                    end else if (src == src_pointer) begin
                        state_reg <= f_ptr;
                    end else begin
                        state_reg <= f_lo;
                    end
                end
                f_ptr: if (mem_rd_valid) begin
                    addr_reg  <= mem_rd_data;
                    state_reg <= f_lo;
                end
                f_lo: if (mem_rd_valid) begin
                    lo_reg <= mem_rd_data;
                    if (double_reg) begin
                        addr_reg  <= addr_reg + ADDR_STEP;
                        state_reg <= f_hi;
                    end else begin
                        operand       <= {WORD_ZERO, mem_rd_data};
                        operand_valid <= 1'b1;
                        state_reg     <= f_idle;
                    end
                end
                f_hi: if (mem_rd_valid) begin
                    operand       <= {mem_rd_data, lo_reg};
                    operand_valid <= 1'b1;
                    state_reg     <= f_idle;
                end
                default: state_reg <= f_idle;
            endcase
        end
    end

    a_double_pair: assert property (
        @(posedge clk) disable iff (!rst_n)
        (state_reg == f_hi && mem_rd_valid)
            |=> operand_valid && operand[WORD_W-1:0] == $past(lo_reg)
                && mem_addr == $past(addr_reg))
        else $error("double operand not built from two words");

endmodule // operand_fetch
`default_nettype wire

// ---- rtl/div_seq.sv ----
/*
 * Restoring divider, one quotient bit per clock.
 * Assumes the caller never starts it with a zero divisor.
 */
`timescale 1ns/10ps
`default_nettype none
module div_seq #(
    parameter int DIVIDEND_W = 32,
    parameter int DIVISOR_W  = 16
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  start,
    input  wire logic [DIVIDEND_W-1:0] dividend,
    input  wire logic [DIVISOR_W-1:0]  divisor,
    output logic                       done,
    output logic [DIVIDEND_W-1:0]      quotient,
    output logic [DIVISOR_W-1:0]       remainder
);

    localparam int CNT_W = $clog2(DIVIDEND_W + 1);
    localparam logic [CNT_W-1:0] STEPS = CNT_W'(DIVIDEND_W);

    logic                  busy_reg;
    logic [CNT_W-1:0]      cnt_reg;
    logic [DIVISOR_W-1:0]  div_reg;
    logic [DIVIDEND_W-1:0] dvd_reg;
    logic [DIVISOR_W:0]    trial;
    logic [DIVISOR_W:0]    trial_diff;
    logic                  fits;

    assign trial      = {remainder, quotient[DIVIDEND_W-1]};
    assign trial_diff = trial - {1'b0, div_reg};
    assign fits       = (trial >= {1'b0, div_reg});

    always_ff @(posedge clk) begin
        done <= 1'b0;
        if (!rst_n) begin
            busy_reg  <= 1'b0;
            cnt_reg   <= '0;
            div_reg   <= '0;
            dvd_reg   <= '0;
            quotient  <= '0;
            remainder <= '0;
        end else if (start && !busy_reg) begin
            busy_reg  <= 1'b1;
            cnt_reg   <= STEPS;
            div_reg   <= divisor;
            dvd_reg   <= dividend;
            quotient  <= dividend;
            remainder <= '0;
        end else if (busy_reg) begin
            remainder <= fits ? trial_diff[DIVISOR_W-1:0]
                              : trial[DIVISOR_W-1:0];
            quotient  <= {quotient[DIVIDEND_W-2:0], fits};
            cnt_reg   <= cnt_reg - 1'b1;
            if (cnt_reg == CNT_W'(1)) begin
                busy_reg <= 1'b0;
                done     <= 1'b1;
            end
        end
    end

    a_div_identity: assert property (
        @(posedge clk) disable iff (!rst_n)
        done |-> (DIVIDEND_W + DIVISOR_W)'(quotient) * div_reg
                 + remainder == dvd_reg && remainder < div_reg)
        else $error("quotient and remainder do not rebuild dividend");

endmodule // div_seq
`default_nettype wire

// ---- rtl/binary_accumulator_arith.sv ----
/*
 * Accumulator arithmetic unit: double add, single and double
 * subtract, multiply and divide, with status flags.
 * Assumes the sequencer waits for BUSY low before each START and
 * that loading the accumulator happens only while idle.
 */
`timescale 1ns/10ps
`default_nettype none
module binary_accumulator_arith
    import arith_pkg::*;
(
    input  wire logic              CORE_CLK,
    input  wire logic              RST_N,
    input  wire logic              START,
    input  wire instr_t            INSTR,
    input  wire logic              ACC_LOAD,
    input  wire logic [ACC_W-1:0]  ACC_LOAD_DATA,
    output logic                   MEM_RD_REQ,
    output logic [ADDR_W-1:0]      MEM_ADDR,
    input  wire logic              MEM_RD_VALID,
    input  wire logic [WORD_W-1:0] MEM_RD_DATA,
    output logic                   BUSY,
    output logic                   DONE,
    output logic [ACC_W-1:0]       ACC,
    output logic                   STACK_PUSH,
    output logic [WORD_W-1:0]      STACK_DATA,
    output status_flags_t          FLAGS
);

    // ----------------------------------------------------------------
    // control state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {st_idle, st_fetch, st_divide} state_t;

    state_t        state_reg;
    state_t        state_next;
    instr_t        instr_reg;
    logic [ACC_W-1:0] acc_reg;
    status_flags_t flags_reg;
    status_flags_t flags_next;

    logic             take;
    logic             start_double;
    logic             operand_valid;
    logic [ACC_W-1:0] operand;
    logic             is_div;
    logic             divisor_zero;
    logic             exec_now;
    logic             div_start;
    logic             div_done;
    logic             commit;
    logic [ACC_W-1:0]  quotient;
    logic [WORD_W-1:0] remainder;

    assign take         = START && (state_reg == st_idle);
    assign start_double = (INSTR.opcode == add_binary_double_op)
                       || (INSTR.opcode == sub_binary_double_op);
    assign is_div       = (instr_reg.opcode == div_binary_op);
    assign divisor_zero = (operand[WORD_W-1:0] == WORD_ZERO);
    assign div_start    = (state_reg == st_fetch) && operand_valid
                       && is_div && !divisor_zero;
    assign exec_now     = (state_reg == st_fetch) && operand_valid
                       && !div_start;
    assign commit       = exec_now || div_done;
    assign BUSY         = (state_reg != st_idle);
    assign ACC          = acc_reg;
    assign FLAGS        = flags_reg;

    // ----------------------------------------------------------------
    // operand fetch and divider
    // ----------------------------------------------------------------
    operand_fetch u_fetch (
        .clk           (CORE_CLK),
        .rst_n         (RST_N),
        .start         (take),
        .src           (INSTR.src),
        .double_word   (start_double),
        .addr          (INSTR.addr),
        .const_value   (INSTR.const_value),
        .mem_rd_req    (MEM_RD_REQ),
        .mem_addr      (MEM_ADDR),
        .mem_rd_valid  (MEM_RD_VALID),
        .mem_rd_data   (MEM_RD_DATA),
        .operand_valid (operand_valid),
        .operand       (operand)
    );

    div_seq #(
        .DIVIDEND_W (ACC_W),
        .DIVISOR_W  (WORD_W)
    ) u_div (
        .clk       (CORE_CLK),
        .rst_n     (RST_N),
        .start     (div_start),
        .dividend  (acc_reg),
        .divisor   (operand[WORD_W-1:0]),
        .done      (div_done),
        .quotient  (quotient),
        .remainder (remainder)
    );

    // ----------------------------------------------------------------
    // arithmetic
    // ----------------------------------------------------------------
    logic [ACC_W:0]    add_sum;
    logic [WORD_W:0]   add_low;
    logic [ACC_W:0]    sub_diff;
    logic [WORD_W:0]   sub_low;
    logic [ACC_W-1:0]  mul_prod;
    logic              add_sign_err;
    logic [ACC_W-1:0]  acc_result;

    assign add_sum  = {1'b0, acc_reg} + {1'b0, operand};
    assign add_low  = {1'b0, acc_reg[HALF_MSB:0]}
                    + {1'b0, operand[HALF_MSB:0]};
    assign sub_diff = {1'b0, acc_reg} - {1'b0, operand};
    assign sub_low  = {1'b0, acc_reg[HALF_MSB:0]}
                    - {1'b0, operand[HALF_MSB:0]};
    assign mul_prod = ACC_W'(acc_reg[HALF_MSB:0])
                    * ACC_W'(operand[HALF_MSB:0]);
    assign add_sign_err = (acc_reg[SIGN_BIT] == operand[SIGN_BIT])
                       && (add_sum[SIGN_BIT] != acc_reg[SIGN_BIT]);

    assign acc_result =
        div_done ? quotient :
        (instr_reg.opcode == add_binary_double_op) ? add_sum[ACC_W-1:0] :
        (instr_reg.opcode == sub_binary_op)
            ? {WORD_ZERO, sub_low[WORD_W-1:0]} :
        (instr_reg.opcode == sub_binary_double_op) ? sub_diff[ACC_W-1:0] :
        (instr_reg.opcode == mul_binary_op) ? mul_prod :
        acc_reg;

    // ----------------------------------------------------------------
    // flags
    // ----------------------------------------------------------------
    always_comb begin
        flags_next = flags_reg;
        if (commit) begin
            flags_next.zero_result_flag     = (acc_result == ACC_RESET);
            flags_next.negative_result_flag = acc_result[SIGN_BIT];
            case (instr_reg.opcode)
                add_binary_double_op: begin
                    flags_next.carry16_flag    = add_low[WORD_W];
                    flags_next.carry32_flag    = add_sum[ACC_W];
                    flags_next.sign_error_flag = add_sign_err;
                end
                sub_binary_op: begin
                    flags_next.borrow16_flag = sub_low[WORD_W];
                end
                sub_binary_double_op: begin
                    flags_next.borrow16_flag = sub_low[WORD_W];
                    flags_next.borrow32_flag = sub_diff[ACC_W];
                end
                div_binary_op: begin
                    flags_next.operand_range_error_flag = !div_done;
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            st_idle:   if (take) state_next = st_fetch;
            st_fetch:  if (div_start) state_next = st_divide;
                       else if (exec_now) state_next = st_idle;
            st_divide: if (div_done) state_next = st_idle;
            default:   state_next = st_idle;
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state_reg <= st_idle;
            instr_reg <= '0;
            flags_reg <= FLAGS_RESET;
        end else begin
            state_reg <= state_next;
            flags_reg <= flags_next;
            if (take) instr_reg <= INSTR;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            acc_reg <= ACC_RESET;
        end else if (commit) begin
            acc_reg <= acc_result;
        end else if (ACC_LOAD && state_reg == st_idle) begin
            acc_reg <= ACC_LOAD_DATA;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            DONE       <= 1'b0;
            STACK_PUSH <= 1'b0;
            STACK_DATA <= WORD_ZERO;
        end else begin
            DONE       <= commit;
            STACK_PUSH <= div_done;
            if (div_done) STACK_DATA <= remainder;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_add_double_sum: assert property (
        @(posedge CORE_CLK) disable iff (!RST_N)
        (exec_now && instr_reg.opcode == add_binary_double_op)
            |=> DONE && ACC == $past(acc_reg) + $past(operand))
        else $error("double add result wrong");

    a_sub_single_diff: assert property (
        @(posedge CORE_CLK) disable iff (!RST_N)
        (exec_now && instr_reg.opcode == sub_binary_op)
            |=> ACC[HALF_MSB:0] == WORD_W'($past(acc_reg[HALF_MSB:0])
                                         - $past(operand[HALF_MSB:0])))
        else $error("single subtract result wrong");

    a_sub_double_diff: assert property (
        @(posedge CORE_CLK) disable iff (!RST_N)
        (exec_now && instr_reg.opcode == sub_binary_double_op)
            |=> ACC == $past(acc_reg) - $past(operand)
                && FLAGS.borrow32_flag == ($past(acc_reg) < $past(operand)))
        else $error("double subtract result or borrow wrong");

    a_mul_product: assert property (
        @(posedge CORE_CLK) disable iff (!RST_N)
        (exec_now && instr_reg.opcode == mul_binary_op)
            |=> ACC == ACC_W'($past(acc_reg[HALF_MSB:0]))
                     * ACC_W'($past(operand[HALF_MSB:0])))
        else $error("multiply result wrong");

    a_range_error: assert property (
        @(posedge CORE_CLK) disable iff (!RST_N)
        (exec_now && is_div)
            |=> FLAGS.operand_range_error_flag && ACC == $past(acc_reg)
                && !STACK_PUSH)
        else $error("zero divisor not flagged");

    a_zero_neg_flags: assert property (
        @(posedge CORE_CLK) disable iff (!RST_N)
        DONE |-> FLAGS.zero_result_flag == (ACC == ACC_RESET)
              && FLAGS.negative_result_flag == ACC[SIGN_BIT])
        else $error("zero or negative flag disagrees with accumulator");

    a_carry32_out: assert property (
        @(posedge CORE_CLK) disable iff (!RST_N)
        (exec_now && instr_reg.opcode == add_binary_double_op)
            |=> FLAGS.carry32_flag == (ACC < $past(acc_reg)))
        else $error("carry32 flag wrong");

    a_flags_hold: assert property (
        @(posedge CORE_CLK) disable iff (!RST_N)
        !DONE |-> $stable(FLAGS))
        else $error("flags changed without an instruction");

    a_div_push: assert property (
        @(posedge CORE_CLK) disable iff (!RST_N)
        div_start |-> ##[32:34] (STACK_PUSH && DONE))
        else $error("divide did not complete with a push");

    a_carry16_out: assert property (
        @(posedge CORE_CLK) disable iff (!RST_N)
        (exec_now && instr_reg.opcode == add_binary_double_op)
            |=> FLAGS.carry16_flag
                == (ACC[HALF_MSB:0] < $past(acc_reg[HALF_MSB:0])))
        else $error("carry16 flag wrong");

    a_borrow16_out: assert property (
        @(posedge CORE_CLK) disable iff (!RST_N)
        (exec_now && (instr_reg.opcode == sub_binary_op
                   || instr_reg.opcode == sub_binary_double_op))
            |=> FLAGS.borrow16_flag == ($past(acc_reg[HALF_MSB:0])
                                      < $past(operand[HALF_MSB:0])))
        else $error("borrow16 flag wrong");

    a_sign_error: assert property (
        @(posedge CORE_CLK) disable iff (!RST_N)
        (exec_now && instr_reg.opcode == add_binary_double_op)
            |=> FLAGS.sign_error_flag
                == ($past(acc_reg[SIGN_BIT]) == $past(operand[SIGN_BIT])
                    && ACC[SIGN_BIT] != $past(acc_reg[SIGN_BIT])))
        else $error("sign error flag wrong");

    a_stack_hold: assert property (
        @(posedge CORE_CLK) disable iff (!RST_N)
        !STACK_PUSH |-> $stable(STACK_DATA))
        else $error("stack data changed without a push");

    a_range_clear: assert property (
        @(posedge CORE_CLK) disable iff (!RST_N)
        div_done |=> !FLAGS.operand_range_error_flag && STACK_PUSH)
        else $error("good divide left range error set");

    a_load_refused: assert property (
        @(posedge CORE_CLK) disable iff (!RST_N)
        (ACC_LOAD && BUSY && !commit) |=> ACC == $past(acc_reg))
        else $error("accumulator loaded while busy");

endmodule // binary_accumulator_arith
`default_nettype wire

// ---- tb/mem_model.sv ----
/*
 * Data memory model facing the arithmetic unit's read port.
 * Assumes a held request; answers after delay cycles with a
 * one-cycle valid, and shows inverted stale data when idle.
 */
`timescale 1ns/10ps
`default_nettype none
module mem_model
    import arith_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [1:0]        delay,
    input  wire logic              rd_req,
    input  wire logic [ADDR_W-1:0] addr,
    output logic                   rd_valid,
    output logic [WORD_W-1:0]      rd_data
);
    // ------------------------------------------------------------
    // storage and answer
    // ------------------------------------------------------------
    logic [WORD_W-1:0] mem [0:255];
    logic [1:0]        wait_reg;
    logic [WORD_W-1:0] last_reg;

    assign rd_valid = rd_req && (wait_reg == delay);
    assign rd_data  = rd_valid ? mem[addr[7:0]] : ~last_reg;

    always_ff @(posedge clk) begin
        if (!rst_n || rd_valid) begin
            wait_reg <= 2'h0;
        end else if (rd_req) begin
            wait_reg <= wait_reg + 2'h1;
        end
        if (!rst_n) begin
            last_reg <= 16'h0000;
        end else if (rd_valid) begin
            last_reg <= rd_data;
        end
    end
endmodule // mem_model
`default_nettype wire

// ---- tb/binary_accumulator_arith_bench.sv ----
/*
 * Self-checking bench for the accumulator arithmetic unit.
 * Assumes the memory model in mem_model.sv; inputs change at the
 * falling edge of a 25 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none
module binary_accumulator_arith_bench
    import arith_pkg::*;
;
    logic              core_clk;
    logic              rst_n;
    logic              start;
    instr_t            instr;
    logic              acc_load;
    logic [ACC_W-1:0]  acc_load_data;
    logic              mem_req;
    logic [ADDR_W-1:0] mem_addr;
    logic              mem_valid;
    logic [WORD_W-1:0] mem_data;
    logic              busy;
    logic              done;
    logic [ACC_W-1:0]  acc;
    logic              push;
    logic [WORD_W-1:0] stack_data;
    status_flags_t     flags;
    logic [1:0]        delay;
    int                error_cnt;
    int                compares;

    binary_accumulator_arith DUT (
        .CORE_CLK(core_clk), .RST_N(rst_n), .START(start),
        .INSTR(instr), .ACC_LOAD(acc_load),
        .ACC_LOAD_DATA(acc_load_data), .MEM_RD_REQ(mem_req),
        .MEM_ADDR(mem_addr), .MEM_RD_VALID(mem_valid),
        .MEM_RD_DATA(mem_data), .BUSY(busy), .DONE(done), .ACC(acc),
        .STACK_PUSH(push), .STACK_DATA(stack_data), .FLAGS(flags));

    mem_model mem_i (
        .clk(core_clk), .rst_n(rst_n), .delay(delay), .rd_req(mem_req),
        .addr(mem_addr), .rd_valid(mem_valid), .rd_data(mem_data));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic load_acc(input logic [ACC_W-1:0] v);
        @(negedge core_clk);
        acc_load      = 1'b1;
        acc_load_data = v;
        @(negedge core_clk);
        acc_load = 1'b0;
    endtask

    // issue one instruction, wait for done, judge accumulator and flags
    task automatic run(input opcode_t op, input src_mode_t src,
                       input logic [15:0] a, input logic [31:0] c,
                       input logic [31:0] exp_acc, input logic [7:0] exp_f,
                       input logic exp_push, input logic poke);
        int n;
        @(negedge core_clk);
        start = 1'b1;
        instr = '{op, src, a, c};
        @(negedge core_clk);
        start         = poke;
        acc_load      = poke;
        acc_load_data = 32'h0000_0000;
        @(negedge core_clk);
        start    = 1'b0;
        acc_load = 1'b0;
        for (n = 0; n < 80 && done !== 1'b1; n++) begin
            @(negedge core_clk);
        end
        if (n == 80) begin
            error_cnt++;
            $display("BAD %0t no done", $time);
            wrap_up();
        end
        check(acc, exp_acc, "acc");
        check({24'h0, flags}, {24'h0, exp_f}, "flags");
        check({31'h0, push}, {31'h0, exp_push}, "stack push");
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check(acc, 32'h0000_0000, "acc reset");
        check({24'h0, flags}, 32'h0000_0000, "flags reset");
    endtask

    task automatic t_add();
        load_acc(32'hffff_ffff);
        run(add_binary_double_op, src_constant, 16'h0000, 32'h0000_0001,
            32'h0000_0000, 8'h4c, 1'b0, 1'b0);
        load_acc(32'h7fff_ffff);
        run(add_binary_double_op, src_constant, 16'h0000, 32'h0000_0001,
            32'h8000_0000, 8'h0b, 1'b0, 1'b0);
    endtask

    task automatic t_sub();
        load_acc(32'h0000_0001);
        run(sub_binary_double_op, src_constant, 16'h0000, 32'h0000_0002,
            32'hffff_ffff, 8'h3b, 1'b0, 1'b0);
        load_acc(32'h0000_0005);
        delay = 2'h1;
        run(sub_binary_op, src_direct, 16'h0030, 32'h0000_0000,
            32'h0000_ffff, 8'h39, 1'b0, 1'b0);
    endtask

    task automatic t_mem();
        load_acc(32'h0000_0001);
        delay = 2'h0;
        run(add_binary_double_op, src_direct, 16'h0010, 32'h0000_0000,
            32'h1234_5679, 8'h30, 1'b0, 1'b0);
        load_acc(32'h0000_0000);
        delay = 2'h3;
        run(add_binary_double_op, src_pointer, 16'h0020, 32'h0000_0000,
            32'h1234_5678, 8'h30, 1'b0, 1'b0);
    endtask

    task automatic t_mul();
        load_acc(32'h0000_ffff);
        run(mul_binary_op, src_constant, 16'h0000, 32'h0000_ffff,
            32'hfffe_0001, 8'h32, 1'b0, 1'b0);
        load_acc(32'h0000_0005);
        run(mul_binary_op, src_constant, 16'h0000, 32'h0000_0000,
            32'h0000_0000, 8'h70, 1'b0, 1'b0);
    endtask

    task automatic t_div();
        load_acc(32'h0000_0064);
        run(div_binary_op, src_constant, 16'h0000, 32'h0000_0007,
            32'h0000_000e, 8'h30, 1'b1, 1'b1);
        check({16'h0, stack_data}, 32'h0000_0002, "remainder");
        @(negedge core_clk);
        check({31'h0, busy}, 32'h0000_0000, "start while busy");
        load_acc(32'h0000_0009);
        run(div_binary_op, src_constant, 16'h0000, 32'h0000_0000,
            32'h0000_0009, 8'hb0, 1'b0, 1'b0);
        check({16'h0, stack_data}, 32'h0000_0002, "stack held");
    endtask

    // ------------------------------------------------------------
    // clock, reset, main sequence
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    initial begin
        error_cnt     = 0;
        compares      = 0;
        rst_n         = 1'b0;
        start         = 1'b0;
        instr         = '0;
        acc_load      = 1'b0;
        acc_load_data = 32'h0000_0000;
        delay         = 2'h0;
        mem_i.mem[8'h10] = 16'h5678;
        mem_i.mem[8'h11] = 16'h1234;
        mem_i.mem[8'h20] = 16'h0010;
        mem_i.mem[8'h30] = 16'h0006;
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        t_reset();
        t_add();
        t_sub();
        t_mem();
        t_mul();
        t_div();
        wrap_up();
    end
endmodule // binary_accumulator_arith_bench
`default_nettype wire
